/* File: hw/video_422_to_444_converter.sv */
// Multiplexed 4:2:2 video to three full-rate channels.
// Assumes a source synchronous to I_CLK and DACs on the ports.
// Functional notes
// - Split input into luma, Cb, Cr
// - Interpolate luma x2, chroma x4
// - Align phase on alignment high-then-low
// - Keep phase while alignment stays low
// - Drive input high sets O_OUT_PORT_OE_N high
// - Matrix select converts to RGB
// - Ports A, B, C carry Y/G, Cb/B, Cr/R
// - Sin(x)/x enable filters all channels
// - Pedestal input may change every cycle
// - Pedestal scales by 947/1024, adds 71
// - Chroma format selects signed or offset
// - Offset binary inverts sign bit
// - RGB mode forces unsigned ports B, C
// - Port A always unsigned
// - Rounding select picks 10 or 8 bits
// - 8-bit: add at bit 1, clear two
// - Correction precedes output rounding
// - Everything on rising clock edge
// - One input word per clock
// - Open inputs default per pin pulls
`timescale 1ns/100ps
`include "video_conv_defs.svh"
module video_422_to_444_converter
    import video_conv_pkg::*;
#(
    parameter int WIDTH = 10
)
(
    input  wire logic             I_CLK,
    input  wire logic             I_RST,
    input  wire logic [WIDTH-1:0] I_IN_WORD,
    input  wire logic             I_PHASE_ALIGN,
    input  wire logic             I_OUT_DRIVE_N,
    input  wire logic             I_RGB_MATRIX_ON,
    input  wire logic             I_SINX_ON,
    input  wire logic             I_PEDESTAL_ON,
    input  wire logic             I_CHROMA_SIGNED,
    input  wire logic             I_ROUND_WIDTH_SEL,
    output logic      [WIDTH-1:0] O_OUT_PORT_A,
    output logic      [WIDTH-1:0] O_OUT_PORT_B,
    output logic      [WIDTH-1:0] O_OUT_PORT_C,
    output logic                  O_OUT_PORT_OE_N
);

    // Demultiplexer phase
    logic   align_d;
    phase_t phase;
    phase_t cur_phase;
    phase_t next_phase;

    // Input word as luma and as signed chroma
    samp_t  luma_in;
    samp_t  chroma_in;

    // Luma half-band interpolator
    samp_t              ly0;
    samp_t              ly1;
    samp_t              ly2;
    logic               luma_arrive;
    logic signed [16:0] hb_acc;
    samp_t              y_i;

    // Chroma linear interpolators
    samp_t              cb_prev;
    samp_t              cb_cur;
    samp_t              cr_prev;
    samp_t              cr_cur;
    logic        [1:0]  k_cb;
    logic        [1:0]  k_cr;
    logic signed [16:0] cb_step;
    logic signed [16:0] cr_step;
    samp_t              cb_i;
    samp_t              cr_i;

    // Cosite alignment delays
    samp_t y_dly  [`VC_Y_ALIGN];
    samp_t cb_dly [`VC_CB_ALIGN];

    // Matrix and pedestal stage
    logic signed [25:0] mat_g;
    logic signed [25:0] mat_b;
    logic signed [25:0] mat_r;
    logic signed [25:0] ped;
    samp_t              st_a;
    samp_t              st_b;
    samp_t              st_c;
    logic               rgb2;

    pix_if px ();

    // Alignment is the falling edge: high last cycle, low now
    always_comb
    begin
        if (align_d && !I_PHASE_ALIGN)
            cur_phase = PH_CB;
        else
            cur_phase = phase;
    end

    always_comb
    begin
        case (cur_phase)
            PH_CB:   next_phase = PH_Y0;
            PH_Y0:   next_phase = PH_CR;
            PH_CR:   next_phase = PH_Y1;
            PH_Y1:   next_phase = PH_CB;
            default: next_phase = PH_CB;
        endcase
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
            align_d <= 1'b0;
        else
            align_d <= I_PHASE_ALIGN;
    end

    // Free-runs one word per clock until realigned
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
            phase <= PH_CB;
        else
            phase <= next_phase;
    end

    // Chroma arrives offset binary; flip the sign bit to centre it
    assign luma_in   = samp_t'({3'b000, I_IN_WORD});
    assign chroma_in = samp_t'({{4{~I_IN_WORD[WIDTH-1]}},
                                I_IN_WORD[WIDTH-2:0]});

    assign luma_arrive = (cur_phase == PH_Y0) || (cur_phase == PH_Y1);

    // Midpoint between ly1 and ly0, using ly2 and the new word
    assign hb_acc = `VC_HB_TAP * (ly1 + ly0) - (ly2 + luma_in);

    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            ly0 <= '0;
            ly1 <= '0;
            ly2 <= '0;
        end
        else if (luma_arrive)
        begin
            ly0 <= luma_in;
            ly1 <= ly0;
            ly2 <= ly1;
        end
    end

    // Arrival cycle emits the midpoint, the next one the sample
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
            y_i <= '0;
        else if (luma_arrive)
            y_i <= samp_t'(hb_acc >>> `VC_HB_SHIFT);
        else
            y_i <= ly0;
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            cb_prev <= '0;
            cb_cur  <= '0;
        end
        else if (cur_phase == PH_CB)
        begin
            cb_prev <= cb_cur;
            cb_cur  <= chroma_in;
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            cr_prev <= '0;
            cr_cur  <= '0;
        end
        else if (cur_phase == PH_CR)
        begin
            cr_prev <= cr_cur;
            cr_cur  <= chroma_in;
        end
    end

    // Step index counts from the cycle after each arrival
    always_comb
    begin
        case (cur_phase)
            PH_Y0:   k_cb = 2'h0;
            PH_CR:   k_cb = 2'h1;
            PH_Y1:   k_cb = 2'h2;
            PH_CB:   k_cb = 2'h3;
            default: k_cb = 2'h0;
        endcase
    end

    always_comb
    begin
        case (cur_phase)
            PH_Y1:   k_cr = 2'h0;
            PH_CB:   k_cr = 2'h1;
            PH_Y0:   k_cr = 2'h2;
            PH_CR:   k_cr = 2'h3;
            default: k_cr = 2'h0;
        endcase
    end

    // Triangle kernel: linear phase, unity gain at DC
    assign cb_step = (cb_cur - cb_prev) * $signed({1'b0, k_cb});
    assign cr_step = (cr_cur - cr_prev) * $signed({1'b0, k_cr});

    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            cb_i <= '0;
            cr_i <= '0;
        end
        else
        begin
            cb_i <= cb_prev + samp_t'(cb_step >>> `VC_CI_SHIFT);
            cr_i <= cr_prev + samp_t'(cr_step >>> `VC_CI_SHIFT);
        end
    end

    // Red chroma lands last; hold luma and blue until it does
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            for (int i = 0; i < `VC_Y_ALIGN; i++)
                y_dly[i] <= '0;
            for (int i = 0; i < `VC_CB_ALIGN; i++)
                cb_dly[i] <= '0;
        end
        else
        begin
            y_dly[0]  <= y_i;
            cb_dly[0] <= cb_i;
            for (int i = 1; i < `VC_Y_ALIGN; i++)
                y_dly[i] <= y_dly[i-1];
            for (int i = 1; i < `VC_CB_ALIGN; i++)
                cb_dly[i] <= cb_dly[i-1];
        end
    end

    // Matrix products stay wide; no wrap before the clamp
    assign mat_g = (26'(y_dly[`VC_Y_ALIGN-1]) <<< `VC_MAT_SHIFT)
                 - cb_dly[`VC_CB_ALIGN-1] * `VC_MAT_G_CB
                 - cr_i * `VC_MAT_G_CR;
    assign mat_b = (26'(y_dly[`VC_Y_ALIGN-1]) <<< `VC_MAT_SHIFT)
                 + cb_dly[`VC_CB_ALIGN-1] * `VC_MAT_B_CB;
    assign mat_r = (26'(y_dly[`VC_Y_ALIGN-1]) <<< `VC_MAT_SHIFT)
                 + cr_i * `VC_MAT_R_CR;
    assign ped   = ((y_dly[`VC_Y_ALIGN-1] * `VC_PED_MUL)
                 >>> `VC_PED_SHIFT) + `VC_PED_ADD;

    // Matrix and pedestal pins sampled here, at the stage they act on
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            st_a <= '0;
            st_b <= '0;
            st_c <= '0;
            rgb2 <= 1'b0;
        end
        else if (I_RGB_MATRIX_ON)
        begin
            // RGB ignores the pedestal pin
            st_a <= clamp_word(samp_t'(mat_g >>> `VC_MAT_SHIFT),
                               1'b0);
            st_b <= clamp_word(samp_t'(mat_b >>> `VC_MAT_SHIFT),
                               1'b0);
            st_c <= clamp_word(samp_t'(mat_r >>> `VC_MAT_SHIFT),
                               1'b0);
            rgb2 <= 1'b1;
        end
        else
        begin
            if (I_PEDESTAL_ON)
                st_a <= clamp_word(samp_t'(ped), 1'b0);
            else
                st_a <= clamp_word(y_dly[`VC_Y_ALIGN-1], 1'b0);
            st_b <= clamp_word(cb_dly[`VC_CB_ALIGN-1], 1'b1);
            st_c <= clamp_word(cr_i, 1'b1);
            rgb2 <= 1'b0;
        end
    end

    assign px.din[0]  = st_a;
    assign px.din[1]  = st_b;
    assign px.din[2]  = st_c;
    assign px.sgn[0]  = 1'b0;
    assign px.sgn[1]  = !rgb2;
    assign px.sgn[2]  = !rgb2;
    assign px.sinx_on = I_SINX_ON;

    // Correction sits ahead of rounding in both modes
    sinx_corr u_sinx (
        .I_CLK (I_CLK),
        .I_RST (I_RST),
        .px    (px)
    );

    // Optional 8-bit round, then clamp, with the low two cleared
    function automatic logic [WIDTH-1:0] finish(samp_t v,
                                                logic sgn,
                                                logic r10);
        samp_t t;
        t = r10 ? v : v + `VC_RND8;
        t = clamp_word(t, sgn);
        if (!r10)
            t[1:0] = 2'b00;
        return t[WIDTH-1:0];
    endfunction

    // Chroma leaves signed only outside RGB and when asked
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            O_OUT_PORT_A <= '0;
            O_OUT_PORT_B <= '0;
            O_OUT_PORT_C <= '0;
        end
        else
        begin
            O_OUT_PORT_A <= finish(px.dout[0], 1'b0,
                                   I_ROUND_WIDTH_SEL);
            O_OUT_PORT_B <= finish(px.dout[1], !rgb2,
                                   I_ROUND_WIDTH_SEL)
                          ^ {(!rgb2 && !I_CHROMA_SIGNED),
                             {(WIDTH-1){1'b0}}};
            O_OUT_PORT_C <= finish(px.dout[2], !rgb2,
                                   I_ROUND_WIDTH_SEL)
                          ^ {(!rgb2 && !I_CHROMA_SIGNED),
                             {(WIDTH-1){1'b0}}};
        end
    end

    // Enable only; pad pulls set open-pin defaults
    assign O_OUT_PORT_OE_N = I_OUT_DRIVE_N;

endmodule // video_422_to_444_converter

/* File: pkg/video_conv_defs.svh */
// Constants for the 4:2:2 to 4:4:4 video converter.
// Assumes one 10-bit input word and three 10-bit outputs.
`ifndef VIDEO_CONV_DEFS_SVH
`define VIDEO_CONV_DEFS_SVH

// Luma half-band taps: (9*(b+c) - (a+d)) / 16
`define VC_HB_TAP      6'sh09
`define VC_HB_SHIFT    4'h4
// Chroma linear interpolation over four phases
`define VC_CI_SHIFT    2'h2
// Alignment of luma and blue chroma to red chroma
`define VC_Y_ALIGN     5
`define VC_CB_ALIGN    3
// Colour matrix, coefficients over 2048
`define VC_MAT_SHIFT   4'hB
`define VC_MAT_G_CB    14'sh02B1
`define VC_MAT_G_CR    14'sh0596
`define VC_MAT_B_CB    14'sh0DDC
`define VC_MAT_R_CR    14'sh0AF7
// Setup pedestal: y * 947 / 1024 + 71
`define VC_PED_MUL     12'sh03B3
`define VC_PED_SHIFT   4'hA
`define VC_PED_ADD     13'sh0047
// Sin(x)/x correction: (18*x1 - x0 - x2) / 16
`define VC_SX_CTR      6'sh12
`define VC_SX_SHIFT    4'h4
// Output word ranges and 8-bit rounding
`define VC_UMAX        13'sh03FF
`define VC_UMIN        13'sh0000
`define VC_SMAX        13'sh01FF
`define VC_SMIN        13'sh1E00
`define VC_RND8        13'sh0002

`endif

/* File: pkg/video_conv_pkg.sv */
// Types and shared helpers of the video converter.
// Assumes the constants header is on the include path.
`include "video_conv_defs.svh"
package video_conv_pkg;
    typedef logic signed [12:0] samp_t;
    typedef enum logic [1:0] {PH_CB, PH_Y0, PH_CR, PH_Y1} phase_t;

    // Clamp to the unsigned or signed 10-bit word range
    function automatic samp_t clamp_word(samp_t v, logic sgn);
        samp_t hi;
        samp_t lo;
        hi = sgn ? `VC_SMAX : `VC_UMAX;
        lo = sgn ? `VC_SMIN : `VC_UMIN;
        if (v > hi)
            return hi;
        if (v < lo)
            return lo;
        return v;
    endfunction
endpackage

/* File: pkg/pix_if.sv */
// Three-channel sample carrier into the correction filter.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface pix_if
    import video_conv_pkg::*;
();
    samp_t din [3];
    samp_t dout [3];
    logic  sgn [3];
    logic  sinx_on;

    modport feed  (output din, output sgn, output sinx_on, input dout);
    modport stage (input din, input sgn, input sinx_on, output dout);
endinterface

/* File: hw/sinx_corr.sv */
// Sin(x)/x correction for three channels.
// Assumes synchronous reset and samples already range-limited.
`timescale 1ns/100ps
`include "video_conv_defs.svh"
module sinx_corr
    import video_conv_pkg::*;
(
    input  wire logic I_CLK,
    input  wire logic I_RST,
    pix_if.stage      px
);
    genvar ch;
    generate
        for (ch = 0; ch < 3; ch++)
        begin : g_ch
            samp_t              x1;
            samp_t              x2;
            samp_t              y;
            logic signed [18:0] acc;

            // Centre tap one sample behind; two cycles when enabled
            assign acc = `VC_SX_CTR * x1 - px.din[ch] - x2;

            always_ff @(posedge I_CLK)
            begin
                if (I_RST)
                begin
                    x1 <= '0;
                    x2 <= '0;
                    y  <= '0;
                end
                else
                begin
                    x1 <= px.din[ch];
                    x2 <= x1;
                    // Saturates rather than wraps on overshoot
                    y  <= clamp_word(samp_t'(acc >>> `VC_SX_SHIFT),
                                     px.sgn[ch]);
                end
            end

            // Bypass goes straight through, so latency drops by two
            assign px.dout[ch] = px.sinx_on ? y : px.din[ch];
        end
    endgenerate
endmodule // sinx_corr

/* File: sim/video_422_to_444_converter_sva.sv */
// Port-level checks for the video converter.
// Assumes one clock and a bind from the bench top.
`timescale 1ns/100ps
module video_422_to_444_converter_sva #(
    parameter int WIDTH = 10
)
(
    input wire logic             I_CLK,
    input wire logic             I_RST,
    input wire logic [WIDTH-1:0] I_IN_WORD,
    input wire logic             I_PHASE_ALIGN,
    input wire logic             I_OUT_DRIVE_N,
    input wire logic             I_RGB_MATRIX_ON,
    input wire logic             I_SINX_ON,
    input wire logic             I_PEDESTAL_ON,
    input wire logic             I_CHROMA_SIGNED,
    input wire logic             I_ROUND_WIDTH_SEL,
    input wire logic [WIDTH-1:0] O_OUT_PORT_A,
    input wire logic [WIDTH-1:0] O_OUT_PORT_B,
    input wire logic [WIDTH-1:0] O_OUT_PORT_C,
    input wire logic             O_OUT_PORT_OE_N
);
    logic [WIDTH+5:0] vec;
    logic [WIDTH+5:0] prev;
    logic [5:0]       steady;
    logic             flat;

    assign vec = {I_IN_WORD, I_PHASE_ALIGN, I_RGB_MATRIX_ON, I_SINX_ON,
                  I_PEDESTAL_ON, I_CHROMA_SIGNED, I_ROUND_WIDTH_SEL};
    // 40 quiet edges, well past the 16-cycle settling
    assign flat = (steady >= 6'h28) && (vec == prev);

    always_ff @(posedge I_CLK)
    begin
        prev <= vec;
        if (I_RST || vec != prev)
            steady <= 6'h00;
        else if (steady != 6'h3F)
            steady <= steady + 6'h01;
    end

    default clocking cb_main @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    property p_oe_follow;
        O_OUT_PORT_OE_N == I_OUT_DRIVE_N;
    endproperty
    a_oe_follow: assert property (p_oe_follow)
        else $error("Enable does not follow drive input");

    property p_rst_zero;
        $fell(I_RST) |-> O_OUT_PORT_A == '0 && O_OUT_PORT_B == '0
            && O_OUT_PORT_C == '0;
    endproperty
    a_rst_zero: assert property (p_rst_zero)
        else $error("Outputs not cleared by reset");

    property p_rnd8_bits;
        !I_ROUND_WIDTH_SEL |=> (O_OUT_PORT_A[1:0] | O_OUT_PORT_B[1:0]
            | O_OUT_PORT_C[1:0]) == 2'b00;
    endproperty
    a_rnd8_bits: assert property (p_rnd8_bits)
        else $error("Low bits set in 8-bit mode");

    property p_steady;
        flat |-> $stable(O_OUT_PORT_A) && $stable(O_OUT_PORT_B)
            && $stable(O_OUT_PORT_C);
    endproperty
    a_steady: assert property (p_steady)
        else $error("Outputs move on steady input");

    property p_flat_a10;
        flat && I_ROUND_WIDTH_SEL && !I_RGB_MATRIX_ON && !I_PEDESTAL_ON
            |-> O_OUT_PORT_A == I_IN_WORD;
    endproperty
    a_flat_a10: assert property (p_flat_a10)
        else $error("Flat luma not passed at unit gain");

    property p_flat_a8;
        flat && !I_ROUND_WIDTH_SEL && !I_RGB_MATRIX_ON && !I_PEDESTAL_ON
            |-> O_OUT_PORT_A == ((I_IN_WORD > 10'h3FD) ? 10'h3FC
            : ((I_IN_WORD + 10'h002) & 10'h3FC));
    endproperty
    a_flat_a8: assert property (p_flat_a8)
        else $error("Flat luma wrongly rounded");

    property p_chroma_signed;
        flat && I_CHROMA_SIGNED && !I_RGB_MATRIX_ON && I_IN_WORD == 10'h200
            |-> O_OUT_PORT_B == '0 && O_OUT_PORT_C == '0;
    endproperty
    a_chroma_signed: assert property (p_chroma_signed)
        else $error("Signed zero chroma wrong");

    property p_chroma_offset;
        flat && !I_CHROMA_SIGNED && !I_RGB_MATRIX_ON && I_ROUND_WIDTH_SEL
            |-> O_OUT_PORT_B == I_IN_WORD && O_OUT_PORT_C == I_IN_WORD;
    endproperty
    a_chroma_offset: assert property (p_chroma_offset)
        else $error("Offset chroma wrong");

    property p_rgb_unsigned;
        flat && I_RGB_MATRIX_ON && I_IN_WORD == 10'h200
            |-> O_OUT_PORT_B == 10'h200 && O_OUT_PORT_C == 10'h200;
    endproperty
    a_rgb_unsigned: assert property (p_rgb_unsigned)
        else $error("RGB grey not unsigned mid-scale");
endmodule // video_422_to_444_converter_sva

/* File: sim/video_source_model.sv */
// Upstream 4:2:2 word source.
// Assumes the bench changes its controls on the rising edge.
`timescale 1ns/100ps
module video_source_model
(
    input  wire logic       i_clk,
    input  wire logic       i_run,
    input  wire logic       i_pulse,
    input  wire logic [9:0] i_cb,
    input  wire logic [9:0] i_y,
    input  wire logic [9:0] i_cr,
    output logic      [9:0] o_word,
    output logic            o_align
);
    logic [1:0] phase = 2'b00;

    // Falling edge, clear of the sampling edge
    always @(negedge i_clk)
    begin
        if (!i_run)
        begin
            phase <= 2'b00;
            o_word <= 10'h000; // Idle data pins rest at their pull-downs
            o_align <= 1'b1;
        end
        else
        begin
            phase <= phase + 2'b01;
            o_word <= (phase == 2'b00) ? i_cb
                    : (phase == 2'b10) ? i_cr : i_y;
            o_align <= i_pulse && phase == 2'b11;
        end
    end
endmodule // video_source_model

/* File: sim/video_422_to_444_converter_tb.sv */
// Self-checking bench for the video converter.
// Assumes the source model and the port checker beside it.
`timescale 1ns/100ps
module video_422_to_444_converter_tb;
    typedef struct packed {
        logic [9:0] a;
        logic [9:0] b;
        logic [9:0] c;
    } expect_t;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        drive_n = 1'b0;
    logic        rgb = 1'b0;
    logic        sinx = 1'b1;
    logic        ped = 1'b0;
    logic        sgn = 1'b1;
    logic        rnd = 1'b1;
    logic        run = 1'b0;
    logic        pulse = 1'b1;
    logic [9:0]  cb = 10'h000;
    logic [9:0]  y = 10'h000;
    logic [9:0]  cr = 10'h000;
    logic [9:0]  word;
    logic        align;
    logic        oe_n;
    logic [9:0]  port_a;
    logic [9:0]  port_b;
    logic [9:0]  port_c;
    logic [9:0]  prev_a;
    logic [31:0] rv;
    integer      seed = 32'hB556_57F4;
    int          fail_count = 0;
    int          check_count = 0;
    expect_t     notes[$];
    event        sample_ev;

    always #50 clk = ~clk;

    video_source_model src (.i_clk(clk), .i_run(run), .i_pulse(pulse),
        .i_cb(cb), .i_y(y), .i_cr(cr), .o_word(word), .o_align(align));

    video_422_to_444_converter #(.WIDTH(10)) uut (.I_CLK(clk), .I_RST(rst),
        .I_IN_WORD(word), .I_PHASE_ALIGN(align), .I_OUT_DRIVE_N(drive_n),
        .I_RGB_MATRIX_ON(rgb), .I_SINX_ON(sinx), .I_PEDESTAL_ON(ped),
        .I_CHROMA_SIGNED(sgn), .I_ROUND_WIDTH_SEL(rnd),
        .O_OUT_PORT_A(port_a), .O_OUT_PORT_B(port_b),
        .O_OUT_PORT_C(port_c), .O_OUT_PORT_OE_N(oe_n));

    function automatic logic [9:0] outv(input logic [9:0] x,
                                        input logic s, input logic r);
        logic [9:0] t;
        t = (x > 10'h3FD) ? 10'h3FC : ((x + 10'h002) & 10'h3FC);
        return (r ? x : t) ^ {s, 9'h000};
    endfunction

    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Restart mid-phase so every case needs a fresh alignment
    task automatic run_case(input logic [9:0] c0, input logic [9:0] y0,
        input logic [9:0] r0, input logic [5:0] m, input expect_t e);
        @(negedge clk);
        {rgb, ped, sgn, rnd, sinx} = m[5:1];
        drive_n = ~drive_n;
        @(posedge clk);
        run <= 1'b0;
        pulse <= m[0];
        cb <= c0;
        y <= y0;
        cr <= r0;
        repeat (3) @(posedge clk);
        run <= 1'b1;
        // Long enough for the checker's 40 quiet edges to be reached
        repeat (48) @(posedge clk);
        @(negedge clk);
        notes.push_back(e);
        -> sample_ev;
        check({9'h000, oe_n}, {9'h000, drive_n});
        $display("Case done at %0t", $time);
    endtask

    initial
    begin
        expect_t e;
        forever
        begin
            @(sample_ev);
            e = notes.pop_front();
            check(port_a, e.a);
            check(port_b, e.b);
            check(port_c, e.c);
        end
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        results();
    end

    initial
    begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            rv = $random(seed);
            run_case(rv[9:0], rv[19:10], rv[29:20],
                {2'b00, i[1], i[2], i[0], i[0] ^ i[1]},
                '{outv(rv[19:10], 1'b0, i[2]), outv(rv[9:0], i[1], i[2]),
                  outv(rv[29:20], i[1], i[2])});
        end
        run_case(10'h3FF, 10'h3FF, 10'h3FF, 6'b000010,
            '{10'h3FC, 10'h3FC, 10'h3FC});
        rv = $random(seed);
        run_case(rv[9:0], rv[9:0], rv[9:0], 6'b000100,
            '{rv[9:0], rv[9:0], rv[9:0]});
        run_case(10'h200, 10'h200, 10'h200, 6'b001110,
            '{10'h200, 10'h000, 10'h000});
        run_case(10'h200, 10'h200, 10'h200, 6'b111010,
            '{10'h200, 10'h200, 10'h200});
        run_case(10'h000, 10'h000, 10'h000, 6'b010100,
            '{10'h047, 10'h000, 10'h000});
        for (int k = 0; k < 50; k++)
        begin
            @(negedge clk);
            if (k > 40)
                check({9'h000, port_a != prev_a && (port_a == 10'h047
                    || port_a == 10'h000)}, 10'h001);
            prev_a = port_a;
            ped = ~ped;
        end
        $display("Case done at %0t", $time);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        notes.push_back('0);
        -> sample_ev;
        rst = 1'b0;
        @(negedge clk);
        $display("Case done at %0t", $time);
        results();
    end
endmodule // video_422_to_444_converter_tb

bind video_422_to_444_converter video_422_to_444_converter_sva #(
    .WIDTH(WIDTH)) u_sva (.I_CLK(I_CLK), .I_RST(I_RST),
    .I_IN_WORD(I_IN_WORD), .I_PHASE_ALIGN(I_PHASE_ALIGN),
    .I_OUT_DRIVE_N(I_OUT_DRIVE_N), .I_RGB_MATRIX_ON(I_RGB_MATRIX_ON),
    .I_SINX_ON(I_SINX_ON), .I_PEDESTAL_ON(I_PEDESTAL_ON),
    .I_CHROMA_SIGNED(I_CHROMA_SIGNED),
    .I_ROUND_WIDTH_SEL(I_ROUND_WIDTH_SEL), .O_OUT_PORT_A(O_OUT_PORT_A),
    .O_OUT_PORT_B(O_OUT_PORT_B), .O_OUT_PORT_C(O_OUT_PORT_C),
    .O_OUT_PORT_OE_N(O_OUT_PORT_OE_N));
